/* logic/bst_pkg.sv */
// =====================================================================
// Boundary-scan test access port constants
// =====================================================================
package bst_pkg;

    // =================================================================
    // Instruction register
    // =================================================================
    localparam int unsigned IR_WIDTH   = 16;
    localparam int unsigned ID_WIDTH   = 32;

    localparam logic [15:0] OP_BYPASS0 = 16'h0000;
    localparam logic [15:0] OP_BYPASS1 = 16'hFFFF;
    localparam logic [15:0] OP_SAMPLE  = 16'hFFF8;
    localparam logic [15:0] OP_EXTEST  = 16'hFFE8;
    localparam logic [15:0] OP_CLAMP   = 16'hFFEF;
    localparam logic [15:0] OP_IDCODE  = 16'hFFFE;
    localparam logic [15:0] OP_HIGHZ   = 16'hFFCF;

    // Value loaded at Test-Logic-Reset
    localparam logic [15:0] IR_RESET   = OP_IDCODE;
    // Capture pattern for Capture-IR, low two bits 01
    localparam logic [15:0] IR_CAPTURE = 16'h0001;

    // Identification value: arbitrary, not a real maker code
    localparam logic [31:0] ID_VALUE   = 32'h1234_5679;

    // Default count of digital pins with boundary cells
    localparam int unsigned PIN_COUNT  = 8;

    // Input synchroniser depth (three flip-flops)
    localparam int unsigned SYNC_DEPTH = 3;

    // =================================================================
    // TAP controller states
    // =================================================================
    typedef enum logic [3:0] {
        ST_RESET     = 4'b0000,
        ST_IDLE      = 4'b0001,
        ST_SEL_DR    = 4'b0010,
        ST_CAP_DR    = 4'b0011,
        ST_SHIFT_DR  = 4'b0100,
        ST_EXIT1_DR  = 4'b0101,
        ST_PAUSE_DR  = 4'b0110,
        ST_EXIT2_DR  = 4'b0111,
        ST_UPD_DR    = 4'b1000,
        ST_SEL_IR    = 4'b1001,
        ST_CAP_IR    = 4'b1010,
        ST_SHIFT_IR  = 4'b1011,
        ST_EXIT1_IR  = 4'b1100,
        ST_PAUSE_IR  = 4'b1101,
        ST_EXIT2_IR  = 4'b1110,
        ST_UPD_IR    = 4'b1111
    } bst_state_t;

endpackage

/* logic/bst_sync.sv */
`timescale 1ns/1ps
// =====================================================================
// Three-stage input synchroniser with agreement check
// =====================================================================
module bst_sync #(
    parameter int unsigned WIDTH = 4
) (
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    // Asynchronous inputs
    input  wire logic [WIDTH-1:0] async_i,
    // Filtered level
    output logic      [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] level_ff;
    wire  [WIDTH-1:0] agree;

    // Stages two and three must match before the level moves
    assign agree = ~(s2_ff ^ s3_ff);

    // Synchroniser chain; first stage feeds only the second
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_ff  <= '0;
            s2_ff    <= '0;
            s3_ff    <= '0;
            level_ff <= '0;
        end else begin
            meta_ff  <= async_i;
            s2_ff    <= meta_ff;
            s3_ff    <= s2_ff;
            level_ff <= (agree & s3_ff) | (~agree & level_ff);
        end
    end

    assign level_o = level_ff;

endmodule

/* logic/bst_tap.sv */
`timescale 1ns/1ps
// =====================================================================
// Boundary-scan test access port
// =====================================================================
module bst_tap #(
    parameter int unsigned PINS = bst_pkg::PIN_COUNT
) (
    // Clock and reset
    input  wire logic            mclk_i,
    input  wire logic            sys_rst_i,
    // Scan mode select pin
    input  wire logic            scan_mode_i,
    // Test link from the tester
    input  wire logic            tck_i,
    input  wire logic            tms_i,
    input  wire logic            tdi_i,
    // Test data out, output enable active low
    output logic                 tdo_o,
    output logic                 tdo_oe_n_o,
    // Functional side of the digital pins
    input  wire logic [PINS-1:0] core_out_i,
    input  wire logic [PINS-1:0] core_oe_n_i,
    output logic      [PINS-1:0] core_in_o,
    // Digital pads, output enable active low
    input  wire logic [PINS-1:0] pad_in_i,
    output logic      [PINS-1:0] pad_out_o,
    output logic      [PINS-1:0] pad_oe_n_o
);

    // Refuse chain lengths the capture and update logic cannot serve
    if (PINS < 1 || PINS > 256) begin : g_bad_pins
        $error("bst_tap: PINS out of range");
    end

    // =================================================================
    // Input sampling
    // =================================================================
    localparam int unsigned SW = 4;
    localparam int unsigned BW = 2 * PINS;
    wire [SW-1:0] sync_level;
    wire [SW-1:0] async_bus;

    assign async_bus = {scan_mode_i, tck_i, tms_i, tdi_i};

    bst_sync #(
        .WIDTH (SW)
    ) u_sync (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (async_bus),
        .level_o   (sync_level)
    );

    wire scan_en = sync_level[3];
    wire tck_s   = sync_level[2];
    wire tms_s   = sync_level[1];
    wire tdi_s   = sync_level[0];

    logic tck_d_ff;

    // Edges are only seen while the port is selected
    wire tck_rise = scan_en & tck_s & ~tck_d_ff;
    wire tck_fall = scan_en & ~tck_s & tck_d_ff;

    // =================================================================
    // TAP controller
    // =================================================================
    bst_pkg::bst_state_t state_ff;
    bst_pkg::bst_state_t nxt_state;

    // Standard sixteen-state walk steered by TMS
    always_comb begin
        case (state_ff)
            bst_pkg::ST_RESET:    nxt_state = tms_s ? bst_pkg::ST_RESET   : bst_pkg::ST_IDLE;
            bst_pkg::ST_IDLE:     nxt_state = tms_s ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_DR:   nxt_state = tms_s ? bst_pkg::ST_SEL_IR  : bst_pkg::ST_CAP_DR;
            bst_pkg::ST_CAP_DR:   nxt_state = tms_s ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_SHIFT_DR: nxt_state = tms_s ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_EXIT1_DR: nxt_state = tms_s ? bst_pkg::ST_UPD_DR  : bst_pkg::ST_PAUSE_DR;
            bst_pkg::ST_PAUSE_DR: nxt_state = tms_s ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
            bst_pkg::ST_EXIT2_DR: nxt_state = tms_s ? bst_pkg::ST_UPD_DR  : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_UPD_DR:   nxt_state = tms_s ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_IR:   nxt_state = tms_s ? bst_pkg::ST_RESET   : bst_pkg::ST_CAP_IR;
            bst_pkg::ST_CAP_IR:   nxt_state = tms_s ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_SHIFT_IR: nxt_state = tms_s ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_EXIT1_IR: nxt_state = tms_s ? bst_pkg::ST_UPD_IR  : bst_pkg::ST_PAUSE_IR;
            bst_pkg::ST_PAUSE_IR: nxt_state = tms_s ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
            bst_pkg::ST_EXIT2_IR: nxt_state = tms_s ? bst_pkg::ST_UPD_IR  : bst_pkg::ST_SHIFT_IR;
            bst_pkg::ST_UPD_IR:   nxt_state = tms_s ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
            default:              nxt_state = bst_pkg::ST_RESET;
        endcase
    end

    // =================================================================
    // Instruction decode
    // =================================================================
    logic [bst_pkg::IR_WIDTH-1:0] ir_ff;
    logic [bst_pkg::IR_WIDTH-1:0] ir_sh_ff;

    wire op_sample = (ir_ff == bst_pkg::OP_SAMPLE);
    wire op_extest = (ir_ff == bst_pkg::OP_EXTEST);
    wire op_clamp  = (ir_ff == bst_pkg::OP_CLAMP);
    wire op_highz  = (ir_ff == bst_pkg::OP_HIGHZ);
    wire op_idcode = (ir_ff == bst_pkg::OP_IDCODE);
    // Everything else, including both bypass codes, lands on bypass
    wire sel_bsr   = op_sample | op_extest;
    wire sel_id    = op_idcode;
    wire sel_byp   = ~sel_bsr & ~sel_id;
    // Test-driven pins under EXTEST and CLAMP
    wire pins_test = op_extest | op_clamp;

    // =================================================================
    // Data registers
    // =================================================================
    // Boundary cells: per pin one data and one enable cell, digital only
    logic [BW-1:0]                bsr_sh_ff;
    logic [BW-1:0]                bsr_upd_ff;
    logic [bst_pkg::ID_WIDTH-1:0] id_sh_ff;
    logic                         byp_ff;

    wire in_shift_dr = (state_ff == bst_pkg::ST_SHIFT_DR);
    wire in_shift_ir = (state_ff == bst_pkg::ST_SHIFT_IR);
    wire in_cap_dr   = (state_ff == bst_pkg::ST_CAP_DR);

    // Captured pin snapshot: pad inputs and functional enables
    wire [BW-1:0] bsr_capture = {~core_oe_n_i, pad_in_i};

    // TAP registers advance on sampled TCK rising edges
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tck_d_ff <= 1'b0;
        end else begin
            tck_d_ff <= tck_s;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_ff <= bst_pkg::ST_RESET;
        end else if (~scan_en) begin
            state_ff <= bst_pkg::ST_RESET;
        end else if (tck_rise) begin
            state_ff <= nxt_state;
        end
    end

    // Instruction register with reset to the identification code
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ir_ff    <= bst_pkg::IR_RESET;
            ir_sh_ff <= bst_pkg::IR_CAPTURE;
        end else if (state_ff == bst_pkg::ST_RESET) begin
            ir_ff    <= bst_pkg::IR_RESET;
            ir_sh_ff <= bst_pkg::IR_CAPTURE;
        end else if (tck_rise) begin
            if (state_ff == bst_pkg::ST_CAP_IR) begin
                ir_sh_ff <= bst_pkg::IR_CAPTURE;
            end else if (in_shift_ir) begin
                ir_sh_ff <= {tdi_s, ir_sh_ff[bst_pkg::IR_WIDTH-1:1]};
            end else if (state_ff == bst_pkg::ST_UPD_IR) begin
                ir_ff <= ir_sh_ff;
            end
        end
    end

    // Data registers: capture, shift LSB first, update
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bsr_sh_ff  <= '0;
            bsr_upd_ff <= '0;
            id_sh_ff   <= bst_pkg::ID_VALUE;
            byp_ff     <= 1'b0;
        end else if (tck_rise) begin
            if (in_cap_dr) begin
                if (sel_bsr) begin
                    bsr_sh_ff <= bsr_capture;
                end
                id_sh_ff <= bst_pkg::ID_VALUE;
                byp_ff   <= 1'b0;
            end else if (in_shift_dr) begin
                if (sel_bsr) begin
                    bsr_sh_ff <= {tdi_s, bsr_sh_ff[BW-1:1]};
                end
                if (sel_id) begin
                    id_sh_ff <= {tdi_s, id_sh_ff[bst_pkg::ID_WIDTH-1:1]};
                end
                byp_ff <= tdi_s;
            end else if (state_ff == bst_pkg::ST_UPD_DR && sel_bsr) begin
                bsr_upd_ff <= bsr_sh_ff;
            end
        end
    end

    // =================================================================
    // TDO, retimed on the falling TCK edge
    // =================================================================
    wire tdo_bit = in_shift_ir ? ir_sh_ff[0] :
                   sel_bsr     ? bsr_sh_ff[0] :
                   sel_id      ? id_sh_ff[0]  : byp_ff;
    wire tdo_act = in_shift_ir | in_shift_dr;

    logic tdo_ff;
    logic tdo_oe_n_ff;

    // Falling edge launch gives the tester a half period to sample
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tdo_ff      <= 1'b0;
            tdo_oe_n_ff <= 1'b1;
        end else if (~scan_en) begin
            tdo_oe_n_ff <= 1'b1;
        end else if (tck_fall) begin
            tdo_ff      <= tdo_bit;
            tdo_oe_n_ff <= ~tdo_act;
        end
    end

    assign tdo_o      = tdo_ff;
    assign tdo_oe_n_o = tdo_oe_n_ff;

    // =================================================================
    // Pin multiplexing
    // =================================================================
    logic [PINS-1:0] pad_out_ff;
    logic [PINS-1:0] pad_oe_n_ff;
    logic [PINS-1:0] core_in_ff;

    wire test_act = scan_en & pins_test;
    wire [PINS-1:0] nxt_pad_out  = test_act ? bsr_upd_ff[PINS-1:0] : core_out_i;
    wire [PINS-1:0] nxt_pad_oe_n = (scan_en & op_highz) ? {PINS{1'b1}} :
                                   test_act ? ~bsr_upd_ff[BW-1:PINS] :
                                   core_oe_n_i;

    // Registered pad drive, one clock after the source
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pad_out_ff  <= '0;
            pad_oe_n_ff <= '1;
            core_in_ff  <= '0;
        end else begin
            pad_out_ff  <= nxt_pad_out;
            pad_oe_n_ff <= nxt_pad_oe_n;
            core_in_ff  <= pad_in_i;
        end
    end

    assign pad_out_o  = pad_out_ff;
    assign pad_oe_n_o = pad_oe_n_ff;
    assign core_in_o  = core_in_ff;

endmodule

/* tb/bst_tap_properties.sv */
`timescale 1ns/1ps
// ==========
// Port properties of the test access port
// ==========
module bst_tap_properties #(
    parameter int unsigned PINS = 8
) (
    // Clock and reset
    input wire logic            mclk_i,
    input wire logic            sys_rst_i,
    // Link and mode
    input wire logic            scan_mode_i,
    input wire logic            tck_i,
    input wire logic            tms_i,
    input wire logic            tdi_i,
    input wire logic            tdo_o,
    input wire logic            tdo_oe_n_o,
    // Pins
    input wire logic [PINS-1:0] core_out_i,
    input wire logic [PINS-1:0] core_oe_n_i,
    input wire logic [PINS-1:0] core_in_o,
    input wire logic [PINS-1:0] pad_in_i,
    input wire logic [PINS-1:0] pad_out_o,
    input wire logic [PINS-1:0] pad_oe_n_o
);
    logic [3:0] since_fall_ff;
    logic [2:0] hi_cnt_ff;

    // Cycles since a test clock fall; saturates on an idle link
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            since_fall_ff <= 4'hf;
        end else if ($fell(tck_i)) begin
            since_fall_ff <= 4'h0;
        end else if (since_fall_ff != 4'hf) begin
            since_fall_ff <= since_fall_ff + 4'h1;
        end
    end

    // Rises with TMS high, held at five; a TMS-low rise restarts
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hi_cnt_ff <= 3'h0;
        end else if ($rose(tck_i)) begin
            hi_cnt_ff <= !tms_i ? 3'h0 : (hi_cnt_ff == 3'h5) ? 3'h5 : hi_cnt_ff + 3'h1;
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_tdo_after_fall: assert property (scan_mode_i [*8] ##0 $changed(tdo_o) |-> since_fall_ff inside {[3:8]})
        else $error("tdo moved away from a clock fall");
    a_tdo_en_fall: assert property (scan_mode_i [*8] ##0 $changed(tdo_oe_n_o) |-> since_fall_ff inside {[3:8]})
        else $error("tdo enable moved away from a clock fall");
    a_tdo_off_idle: assert property ((!scan_mode_i) [*8] |-> tdo_oe_n_o)
        else $error("tdo driven without scan mode");
    a_tdo_quiet_idle: assert property ((!scan_mode_i) [*8] |=> $stable(tdo_o))
        else $error("tdo moved without scan mode");
    a_pads_follow_core: assert property ((!scan_mode_i) [*8] |-> pad_out_o == $past(core_out_i))
        else $error("pad value not from core");
    a_core_in_path: assert property ((!scan_mode_i) [*8] |-> core_in_o == $past(pad_in_i))
        else $error("core input not from pad");
    a_tms_reset_pads: assert property ((hi_cnt_ff == 3'h5) [*8] |-> pad_oe_n_o == $past(core_oe_n_i))
        else $error("pads not functional after test reset");
    a_reset_outputs: assert property (disable iff (1'b0) sys_rst_i |-> !tdo_o && tdo_oe_n_o && &pad_oe_n_o)
        else $error("outputs not idle in reset");
endmodule

bind bst_tap bst_tap_properties #(.PINS(PINS)) u_props (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .scan_mode_i(scan_mode_i), .tck_i(tck_i), .tms_i(tms_i),
    .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .core_out_i(core_out_i), .core_oe_n_i(core_oe_n_i),
    .core_in_o(core_in_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o)
);

/* tb/bst_tester.sv */
`timescale 1ns/1ps
// ==========
// Scan tester model on the far side of the link
// ==========
module bst_tester (
    // Link
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_n_i
);
    logic tdo_last;

    // Clock parked low between frames
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        tdo_last = 1'b0;
    end

    // One 48 ns clock; inputs move at the fall, TDO read late in the
    // high phase because the port answers several system clocks late
    task automatic pulse(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #24;
        tck_o = 1'b1;
        #23;
        tdo = tdo_oe_n_i ? ~tdo_last : tdo_i;
        tdo_last = tdo;
        #1;
        tck_o = 1'b0;
    endtask

    // Five high rises reach test reset, then park in idle
    task automatic tap_reset();
        logic d;
        repeat (5) pulse(1'b1, 1'b0, d);
        pulse(1'b0, 1'b0, d);
    endtask

    // Idle to shift, n bits LSB first, then update and back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic d;
        dout = '0;
        pulse(1'b1, 1'b0, d);
        if (ir) begin
            pulse(1'b1, 1'b0, d);
        end
        pulse(1'b0, 1'b0, d);
        pulse(1'b0, 1'b0, d);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], dout[i]);
        end
        pulse(1'b1, 1'b0, d);
        pulse(1'b0, 1'b0, d);
    endtask
endmodule

/* tb/bst_tap_tb.sv */
`timescale 1ns/1ps
// ==========
// Test access port bench
// ==========
module bst_tap_tb;
    localparam int unsigned PINS = 8;
    logic            mclk_i, sys_rst_i, scan_mode_i, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_n_o;
    logic [PINS-1:0] core_out_i, core_oe_n_i, core_in_o, pad_in_i, pad_out_o, pad_oe_n_o;
    logic [31:0]     din, got;
    logic [15:0]     code, pre;
    int              fail_count, checked;

    bst_tap #(.PINS(PINS)) dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .scan_mode_i(scan_mode_i),
        .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
        .core_out_i(core_out_i), .core_oe_n_i(core_oe_n_i), .core_in_o(core_in_o), .pad_in_i(pad_in_i),
        .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o));
    bst_tester tester (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o), .tdo_oe_n_i(tdo_oe_n_o));

    // 200 MHz system clock
    always #2.5 mclk_i = ~mclk_i;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Bypass answer: a captured zero, then TDI one clock late
    function automatic logic [31:0] bypass_exp(input logic [31:0] d);
        return {24'h00_0000, d[6:0], 1'b0};
    endfunction

    // Fresh random pin levels just after a clock edge
    task automatic set_pins();
        @(posedge mclk_i);
        #1;
        core_out_i = PINS'($urandom);
        core_oe_n_i = PINS'($urandom);
        pad_in_i = PINS'($urandom);
    endtask

    // Functional mode: pads follow the core one clock later
    task automatic func_check();
        set_pins();
        repeat (3) @(posedge mclk_i);
        check("pad_out", 32'(pad_out_o), 32'(core_out_i));
        check("pad_oe_n", 32'(pad_oe_n_o), 32'(core_oe_n_i));
        check("core_in", 32'(core_in_o), 32'(pad_in_i));
    endtask

    task automatic load_ir(input logic [15:0] c);
        tester.scan(1'b1, 16, {16'h0000, c}, got);
        check("ir_capture", got, {16'h0000, bst_pkg::IR_CAPTURE});
    endtask

    task automatic bypass_check();
        din = $urandom;
        tester.scan(1'b0, 8, din, got);
        check("bypass", got, bypass_exp(din));
    endtask

    task automatic id_check();
        din = $urandom;
        tester.scan(1'b0, 32, din, got);
        check("idcode", got, bst_pkg::ID_VALUE);
    endtask

    // Pads driven from the update latch of the boundary cells, or from the core with all enables off under HIGHZ
    task automatic pad_check(input logic [PINS-1:0] dout, input logic [PINS-1:0] doe_n);
        repeat (4) @(posedge mclk_i);
        check("pad_out", 32'(pad_out_o), 32'(dout));
        check("pad_oe_n", 32'(pad_oe_n_o), 32'(doe_n));
    endtask

    // Main sequence: reset, functional path, every instruction, mode drop
    initial begin
        mclk_i = 1'b0;
        sys_rst_i = 1'b1;
        scan_mode_i = 1'b0;
        core_out_i = '0;
        core_oe_n_i = '1;
        pad_in_i = '0;
        fail_count = 0;
        checked = 0;
        din = $urandom(32'h0000_ba36);
        repeat (16) @(posedge mclk_i);
        #1;
        sys_rst_i = 1'b0;
        func_check();
        #1;
        scan_mode_i = 1'b1;
        repeat (8) @(posedge mclk_i);
        tester.tap_reset();
        id_check();
        // Both bypass codes, an unlisted neighbour, a random unlisted code
        for (int i = 0; i < 4; i++) begin
            code = 16'($urandom);
            if (i < 3 || code inside {bst_pkg::OP_SAMPLE, bst_pkg::OP_EXTEST, bst_pkg::OP_CLAMP,
                                      bst_pkg::OP_IDCODE, bst_pkg::OP_HIGHZ}) begin
                code = i == 0 ? bst_pkg::OP_BYPASS0 : i == 1 ? bst_pkg::OP_BYPASS1 : 16'hfff9;
            end
            load_ir(code);
            bypass_check();
        end
        // Sample and preload, then drive the preloaded and new values
        load_ir(bst_pkg::OP_SAMPLE);
        func_check();
        for (int j = 0; j < 2; j++) begin
            pre = 16'($urandom);
            tester.scan(1'b0, 16, {16'h0000, pre}, got);
            check("boundary", got, {16'h0000, ~core_oe_n_i, pad_in_i});
            if (j == 0) begin
                load_ir(bst_pkg::OP_EXTEST);
            end
            pad_check(pre[7:0], ~pre[15:8]);
        end
        load_ir(bst_pkg::OP_CLAMP);
        bypass_check();
        pad_check(pre[7:0], ~pre[15:8]);
        load_ir(bst_pkg::OP_HIGHZ);
        bypass_check();
        pad_check(core_out_i, '1);
        tester.tap_reset();
        func_check();
        // Mode select low mid-test: link ignored, TAP forced to reset
        load_ir(bst_pkg::OP_EXTEST);
        @(posedge mclk_i);
        #1;
        scan_mode_i = 1'b0;
        tester.scan(1'b1, 16, 32'h0000_ffff, got);
        check("tdo_off", 32'(tdo_oe_n_o), 32'h0000_0001);
        func_check();
        @(posedge mclk_i);
        #1;
        scan_mode_i = 1'b1;
        repeat (8) @(posedge mclk_i);
        tester.pulse(1'b0, 1'b0, got[0]);
        id_check();
        finish_test();
    end

    // Watchdog, far past the expected run of about 21 us
    initial begin
        #200_000;
        fail_count++;
        $display("mismatch watchdog expected finish seen timeout");
        finish_test();
    end
endmodule
